// ==== verilog/fsh_exec.sv ====
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module fsh_exec
  import fsh_pkg::*;
(
  // Clock and reset
  input  wire logic           I_CORE_CLK,
  input  wire logic           I_RESETN,
  // Command
  input  wire fsh_pkg::fsh_cmd_t I_CMD,
  input  wire logic           I_CMD_VALID,
  output logic                O_CMD_READY,
  // Data memory
  output logic         [15:0] O_DMEM_ADDR,
  output logic         [7:0]  O_DMEM_WDATA,
  output logic                O_DMEM_WE,
  output logic                O_DMEM_RE,
  input  wire logic    [7:0]  I_DMEM_RDATA,
  // Program memory
  output logic         [15:0] O_PMEM_ADDR,
  output logic                O_PMEM_RE,
  input  wire logic    [7:0]  I_PMEM_RDATA,
  // I/O space
  output logic         [5:0]  O_IO_ADDR,
  output logic         [7:0]  O_IO_WDATA,
  output logic                O_IO_WE,
  output logic                O_IO_RE,
  input  wire logic    [7:0]  I_IO_RDATA,
  // Register port
  input  wire logic    [1:0]  I_REG_ADDR,
  input  wire logic    [7:0]  I_REG_WDATA,
  input  wire logic           I_REG_WE,
  input  wire logic           I_REG_RE,
  output logic         [7:0]  O_REG_RDATA,
  // Flag word
  output logic         [7:0]  O_FLAGS
);

  // ****************************************
  // State
  // ****************************************
  fsh_state_t  state_r;
  fsh_state_t  state_nxt;
  fsh_cmd_t    cmd_r;
  logic [1:0]  cyc_r;
  logic [7:0]  regs_r [32];
  logic [7:0]  flag_r;
  logic [15:0] sp_r;
  logic [7:0]  mod_r;
  logic [7:0]  rdata_r;

  logic        accept;
  fsh_am_t     am;
  fsh_ptr_t    base;
  logic [15:0] base_val;
  logic [4:0]  base_lo;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic        ptr_upd;
  logic [7:0]  src_val;
  logic [7:0]  dst_val;
  logic [7:0]  bit_mask;
  logic [7:0]  sh_res;
  logic        sh_c;
  logic        sh_z;
  logic        sh_n;
  logic        sh_v;
  logic        is_shift;
  logic        is_store;
  logic        is_crd;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic [7:0]  wr_data;

  // ****************************************
  // Decode
  // ****************************************
  assign accept   = I_CMD_VALID && (state_r == SQ_IDLE);
  assign src_val  = regs_r[I_CMD.src];
  assign dst_val  = regs_r[I_CMD.dst];
  assign bit_mask = 8'h01 << I_CMD.bitsel;
  assign is_shift = (I_CMD.op == OP_SHL) || (I_CMD.op == OP_SHR) ||
                    (I_CMD.op == OP_RLC) || (I_CMD.op == OP_RRC) ||
                    (I_CMD.op == OP_SAR);
  assign is_store = (I_CMD.op == OP_PW_PLAIN) || (I_CMD.op == OP_PW_POSTINC) ||
                    (I_CMD.op == OP_PW_PREDEC) || (I_CMD.op == OP_PW_DISP) ||
                    (I_CMD.op == OP_DSTORE) || (I_CMD.op == OP_PUSH);
  assign is_crd   = (I_CMD.op == OP_CRD_R0) || (I_CMD.op == OP_CRD) ||
                    (I_CMD.op == OP_CRD_INC);

  always_comb
  begin
    am   = AM_PLAIN;
    base = I_CMD.ptr;
    case (I_CMD.op)
      OP_PW_POSTINC: am = AM_POSTINC;
      OP_PW_PREDEC:  am = AM_PREDEC;
      OP_PW_DISP:    am = AM_DISP;
      OP_DSTORE:     am = AM_DIRECT;
      OP_CRD_R0, OP_CRD: base = PTR_Z;
      OP_CRD_INC:
      begin
        am   = AM_POSTINC;
        base = PTR_Z;
      end
      OP_PUSH:
      begin
        am   = AM_POSTDEC;
        base = PTR_SP;
      end
      OP_POP:
      begin
        am   = AM_PREINC;
        base = PTR_SP;
      end
      default: am = AM_PLAIN;
    endcase
  end

  always_comb
  begin
    case (base)
      PTR_X:   base_lo = PTR_X_LO;
      PTR_Y:   base_lo = PTR_Y_LO;
      default: base_lo = PTR_Z_LO;
    endcase
    if (base == PTR_SP)
      base_val = sp_r;
    else
      base_val = {regs_r[base_lo + 5'h01], regs_r[base_lo]};
  end

  fsh_addr u_addr (
    .i_mode    (am),
    .i_ptr     (base_val),
    .i_imm     (I_CMD.imm),
    .o_ea      (ea),
    .o_ptr_new (ptr_new),
    .o_ptr_upd (ptr_upd)
  );

  fsh_shift u_shift (
    .i_op  (I_CMD.op),
    .i_val (dst_val),
    .i_cin (flag_r[FLAG_C]),
    .o_res (sh_res),
    .o_c   (sh_c),
    .o_z   (sh_z),
    .o_n   (sh_n),
    .o_v   (sh_v)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SQ_IDLE: if (accept && (op_cycles(I_CMD.op) != CYC_ONE)) state_nxt = SQ_S1;
      SQ_S1:   state_nxt = (cyc_r == CYC_THREE) ? SQ_S2 : SQ_IDLE;
      SQ_S2:   state_nxt = SQ_IDLE;
      default: state_nxt = SQ_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      state_r <= SQ_IDLE;
      cyc_r   <= CYC_ONE;
      cmd_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (accept)
      begin
        cyc_r <= op_cycles(I_CMD.op);
        cmd_r <= I_CMD;
      end
    end
  end

  assign O_CMD_READY = (state_r == SQ_IDLE);

  // ****************************************
  // Memory and I/O strobes
  // ****************************************
  assign O_DMEM_ADDR  = ea;
  assign O_DMEM_WDATA = src_val;
  assign O_DMEM_WE    = accept && is_store;
  assign O_DMEM_RE    = accept && (I_CMD.op == OP_POP);
  assign O_PMEM_ADDR  = ea;
  assign O_PMEM_RE    = accept && is_crd;

  always_comb
  begin
    if (state_r == SQ_S1 && (cmd_r.op == OP_IOSET || cmd_r.op == OP_IOCLR))
    begin
      O_IO_ADDR  = {1'b0, cmd_r.imm[4:0]};
      O_IO_WDATA = mod_r;
      O_IO_WE    = 1'b1;
      O_IO_RE    = 1'b0;
    end
    else
    begin
      O_IO_ADDR  = (I_CMD.op == OP_IOSET || I_CMD.op == OP_IOCLR) ?
                   {1'b0, I_CMD.imm[4:0]} : I_CMD.imm[5:0];
      O_IO_WDATA = src_val;
      O_IO_WE    = accept && (I_CMD.op == OP_OUT);
      O_IO_RE    = accept && (I_CMD.op == OP_IN || I_CMD.op == OP_IOSET ||
                              I_CMD.op == OP_IOCLR);
    end
  end

  // I/O bit read-modify value, written back in the second cycle
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
      mod_r <= 8'h00;
    else if (accept && I_CMD.op == OP_IOSET)
      mod_r <= I_IO_RDATA | bit_mask;
    else if (accept && I_CMD.op == OP_IOCLR)
      mod_r <= I_IO_RDATA & ~bit_mask;
  end

  // ****************************************
  // Working register writes
  // ****************************************
  always_comb
  begin
    wr_en   = 1'b0;
    wr_idx  = I_CMD.dst;
    wr_data = sh_res;
    if (state_r == SQ_S1 && cmd_r.op == OP_POP)
    begin
      wr_en   = 1'b1;
      wr_idx  = cmd_r.dst;
      wr_data = I_DMEM_RDATA;
    end
    else if (state_r == SQ_S1 && (cmd_r.op == OP_CRD || cmd_r.op == OP_CRD_INC ||
                                  cmd_r.op == OP_CRD_R0))
    begin
      wr_en   = 1'b1;
      wr_idx  = (cmd_r.op == OP_CRD_R0) ? REG_R0 : cmd_r.dst;
      wr_data = I_PMEM_RDATA;
    end
    else if (accept && is_shift)
      wr_en = 1'b1;
    else if (accept && I_CMD.op == OP_T2B)
    begin
      wr_en   = 1'b1;
      wr_data = flag_r[FLAG_T] ? (dst_val | bit_mask) : (dst_val & ~bit_mask);
    end
    else if (accept && I_CMD.op == OP_IN)
    begin
      wr_en   = 1'b1;
      wr_data = I_IO_RDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
    begin
      for (int i = 0; i < 32; i++)
        regs_r[i] <= 8'h00;
    end
    else
    begin
      if (accept && ptr_upd && base != PTR_SP)
      begin
        regs_r[base_lo]         <= ptr_new[7:0];
        regs_r[base_lo + 5'h01] <= ptr_new[15:8];
      end
      if (wr_en)
        regs_r[wr_idx] <= wr_data;
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
      sp_r <= SP_RESET;
    else if (accept && ptr_upd && base == PTR_SP)
      sp_r <= ptr_new;
    else if (I_REG_WE && I_REG_ADDR == REG_SPL)
      sp_r[7:0] <= I_REG_WDATA;
    else if (I_REG_WE && I_REG_ADDR == REG_SPH)
      sp_r[15:8] <= I_REG_WDATA;
  end

  // ****************************************
  // Flag word
  // ****************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
      flag_r <= FLAG_RESET;
    else if (accept && is_shift)
    begin
      flag_r[FLAG_C] <= sh_c;
      flag_r[FLAG_Z] <= sh_z;
      flag_r[FLAG_N] <= sh_n;
      flag_r[FLAG_V] <= sh_v;
    end
    else if (accept && I_CMD.op == OP_B2T)
      flag_r[FLAG_T] <= src_val[I_CMD.bitsel];
    else if (accept && (I_CMD.op == OP_SSET || I_CMD.op == OP_SCLR))
      flag_r[FLAG_S] <= (I_CMD.op == OP_SSET);
    else if (accept && (I_CMD.op == OP_VSET || I_CMD.op == OP_VCLR))
      flag_r[FLAG_V] <= (I_CMD.op == OP_VSET);
    else if (I_REG_WE && I_REG_ADDR == REG_FLAG)
      flag_r <= I_REG_WDATA;
  end

  assign O_FLAGS = flag_r;

  // ****************************************
  // Register port read
  // ****************************************
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RESETN)
      rdata_r <= 8'h00;
    else if (I_REG_RE)
    begin
      case (I_REG_ADDR)
        REG_FLAG:   rdata_r <= flag_r;
        REG_STATUS: rdata_r <= {5'h00, state_r, (state_r != SQ_IDLE)};
        REG_SPL:    rdata_r <= sp_r[7:0];
        REG_SPH:    rdata_r <= sp_r[15:8];
        default:    rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign O_REG_RDATA = rdata_r;

endmodule

// ==== verilog/fsh_pkg.sv ====
// Operation
// - Post-increment store writes source at pointer, then pointer plus one; 2 cycles
// - Pre-decrement store lowers pointer first, then writes source there; 2 cycles
// - Displaced store writes at Y or Z plus offset, pointer kept; 2 cycles
// - Direct store writes source at absolute address from instruction; 2 cycles
// - Code memory read via Z into R0 or named register, optional Z increment; 3 cycles
// - Push puts named register on stack in 2 cycles, flags kept
// - Pop takes next stack byte into named register in 2 cycles, flags kept
// - I/O bit set forces one bit of I/O register high; 2 cycles
// - I/O bit clear forces one bit of I/O register low; 2 cycles
// - Rotate left through carry, updates Z C N V in 1 cycle
// - Rotate right through carry, updates Z C N V in 1 cycle
// - Bit-to-flag copy loads transfer flag from register bit; 1 cycle
// - Flag-to-bit copy writes transfer flag into register bit; 1 cycle
// - Single-cycle set and clear of signed-test flag only
// - Single-cycle set and clear of overflow flag only
package fsh_pkg;

  // ****************************************
  // Flag word layout and reset
  // ****************************************
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_T = 6;
  localparam logic [7:0]  FLAG_RESET = 8'h00;
  localparam logic [15:0] SP_RESET   = 16'h0000;

  // ****************************************
  // Register port offsets
  // ****************************************
  localparam logic [1:0] REG_FLAG   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_SPL    = 2'h2;
  localparam logic [1:0] REG_SPH    = 2'h3;

  // ****************************************
  // Working register indices and cycle counts
  // ****************************************
  localparam logic [4:0] REG_R0   = 5'h00;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    OP_NOP, OP_PW_PLAIN, OP_PW_POSTINC, OP_PW_PREDEC, OP_PW_DISP, OP_DSTORE,
    OP_CRD_R0, OP_CRD, OP_CRD_INC, OP_PUSH, OP_POP, OP_IOSET, OP_IOCLR,
    OP_IN, OP_OUT, OP_SHL, OP_SHR, OP_RLC, OP_RRC, OP_SAR,
    OP_B2T, OP_T2B, OP_SSET, OP_SCLR, OP_VSET, OP_VCLR
  } fsh_op_t;

  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2, PTR_SP = 2'h3} fsh_ptr_t;

  typedef enum logic [2:0] {
    AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP, AM_DIRECT, AM_POSTDEC, AM_PREINC
  } fsh_am_t;

  typedef enum logic [1:0] {SQ_IDLE = 2'h0, SQ_S1 = 2'h1, SQ_S2 = 2'h3} fsh_state_t;

  typedef struct packed {
    fsh_op_t     op;
    logic [4:0]  dst;
    logic [4:0]  src;
    fsh_ptr_t    ptr;
    logic [2:0]  bitsel;
    logic [15:0] imm;
  } fsh_cmd_t;

  function automatic logic [1:0] op_cycles(input fsh_op_t op);
    case (op)
      OP_CRD_R0, OP_CRD, OP_CRD_INC: op_cycles = CYC_THREE;
      OP_PW_PLAIN, OP_PW_POSTINC, OP_PW_PREDEC, OP_PW_DISP, OP_DSTORE,
      OP_PUSH, OP_POP, OP_IOSET, OP_IOCLR: op_cycles = CYC_TWO;
      default: op_cycles = CYC_ONE;
    endcase
  endfunction

endpackage

// ==== verilog/fsh_addr.sv ====
`timescale 1ns/100ps
module fsh_addr
  import fsh_pkg::*;
(
  // Mode and operands
  input  wire fsh_am_t     i_mode,
  input  wire logic [15:0] i_ptr,
  input  wire logic [15:0] i_imm,
  // Results
  output logic      [15:0] o_ea,
  output logic      [15:0] o_ptr_new,
  output logic             o_ptr_upd
);
  always_comb
  begin
    o_ea      = i_ptr;
    o_ptr_new = i_ptr;
    o_ptr_upd = 1'b0;
    case (i_mode)
      AM_POSTINC:
      begin
        o_ptr_new = i_ptr + 16'h0001;
        o_ptr_upd = 1'b1;
      end
      AM_PREDEC:
      begin
        o_ptr_new = i_ptr - 16'h0001;
        o_ea      = o_ptr_new;
        o_ptr_upd = 1'b1;
      end
      AM_DISP:   o_ea = i_ptr + {10'h000, i_imm[5:0]};
      AM_DIRECT: o_ea = i_imm;
      AM_POSTDEC:
      begin
        o_ptr_new = i_ptr - 16'h0001;
        o_ptr_upd = 1'b1;
      end
      AM_PREINC:
      begin
        o_ptr_new = i_ptr + 16'h0001;
        o_ea      = o_ptr_new;
        o_ptr_upd = 1'b1;
      end
      default: o_ea = i_ptr;
    endcase
  end
endmodule

// ==== verilog/fsh_shift.sv ====
`timescale 1ns/100ps
module fsh_shift
  import fsh_pkg::*;
(
  // Operands
  input  wire fsh_op_t    i_op,
  input  wire logic [7:0] i_val,
  input  wire logic       i_cin,
  // Result and flags
  output logic      [7:0] o_res,
  output logic            o_c,
  output logic            o_z,
  output logic            o_n,
  output logic            o_v
);
  always_comb
  begin
    o_res = i_val;
    o_c   = i_cin;
    case (i_op)
      OP_SHL:
      begin
        o_res = {i_val[6:0], 1'b0};
        o_c   = i_val[7];
      end
      OP_SHR:
      begin
        o_res = {1'b0, i_val[7:1]};
        o_c   = i_val[0];
      end
      OP_RLC:
      begin
        o_res = {i_val[6:0], i_cin};
        o_c   = i_val[7];
      end
      OP_RRC:
      begin
        o_res = {i_cin, i_val[7:1]};
        o_c   = i_val[0];
      end
      OP_SAR:
      begin
        o_res = {i_val[7], i_val[7:1]};
        o_c   = i_val[0];
      end
      default: o_res = i_val;
    endcase
    o_n = o_res[7];
    o_z = (o_res == 8'h00);
    o_v = o_n ^ o_c;
  end
endmodule

// ==== verification/fsh_exec_monitor.sv ====
`timescale 1ns/100ps
module fsh_exec_monitor
  import fsh_pkg::*;
(
  // Clock, reset and command
  input wire logic              I_CORE_CLK,
  input wire logic              I_RESETN,
  input wire fsh_pkg::fsh_cmd_t I_CMD,
  input wire logic              I_CMD_VALID,
  input wire logic              O_CMD_READY,
  // Memory and I/O
  input wire logic              O_DMEM_WE,
  input wire logic              O_DMEM_RE,
  input wire logic       [15:0] O_DMEM_ADDR,
  input wire logic              O_PMEM_RE,
  input wire logic              O_IO_WE,
  input wire logic       [7:0]  O_IO_WDATA,
  input wire logic       [7:0]  I_IO_RDATA,
  // Register write and flags
  input wire logic              I_REG_WE,
  input wire logic       [7:0]  O_FLAGS
);
  logic acc;
  assign acc = I_CMD_VALID && O_CMD_READY && !I_REG_WE;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  // ****************************************
  // Assertions
  // ****************************************
  a_store_two_cyc: assert property (O_DMEM_WE |=> !O_CMD_READY ##1 O_CMD_READY)
    else $error("store or push busy time wrong");
  a_pop_two_cyc: assert property (O_DMEM_RE |=> !O_CMD_READY ##1 O_CMD_READY)
    else $error("pop busy time wrong");
  a_code_three_cyc: assert property (O_PMEM_RE |=> !O_CMD_READY [*2] ##1 O_CMD_READY)
    else $error("code read busy time wrong");
  a_direct_addr: assert property (acc && I_CMD.op == OP_DSTORE |-> O_DMEM_WE && O_DMEM_ADDR == I_CMD.imm)
    else $error("direct store address wrong");
  a_io_bit_set: assert property (acc && I_CMD.op == OP_IOSET |=> O_IO_WE &&
    O_IO_WDATA == ($past(I_IO_RDATA) | (8'h01 << $past(I_CMD.bitsel)))) else $error("bit set wrong");
  a_io_bit_clear: assert property (acc && I_CMD.op == OP_IOCLR |=> O_IO_WE &&
    O_IO_WDATA == ($past(I_IO_RDATA) & ~(8'h01 << $past(I_CMD.bitsel)))) else $error("bit clear wrong");
  a_port_one_cyc: assert property (acc && I_CMD.op inside {OP_IN, OP_OUT} |=>
    O_CMD_READY && $stable(O_FLAGS)) else $error("port transfer wrong");
  a_shift_flag_rel: assert property (acc && I_CMD.op inside {OP_SHL, OP_SHR, OP_RLC, OP_RRC, OP_SAR}
    |=> O_FLAGS[3] == (O_FLAGS[2] ^ O_FLAGS[0]) && O_FLAGS[7:4] == $past(O_FLAGS[7:4]))
    else $error("shift flags wrong");
  a_sign_flag_only: assert property (acc && I_CMD.op inside {OP_SSET, OP_SCLR} |=> O_FLAGS ==
    {$past(O_FLAGS[7:5]), ($past(I_CMD.op) == OP_SSET), $past(O_FLAGS[3:0])}) else $error("sign flag wrong");
  a_ovf_flag_only: assert property (acc && I_CMD.op inside {OP_VSET, OP_VCLR} |=> O_FLAGS ==
    {$past(O_FLAGS[7:4]), ($past(I_CMD.op) == OP_VSET), $past(O_FLAGS[2:0])}) else $error("ovf flag wrong");
  a_tflag_others: assert property (acc && I_CMD.op == OP_B2T |=> O_FLAGS[5:0] == $past(O_FLAGS[5:0]))
    else $error("bit copy touched flags");
  c_code_read: cover property (O_PMEM_RE);
  c_pop: cover property (O_DMEM_RE);
  c_bit_set: cover property (acc && I_CMD.op == OP_IOSET);
endmodule
bind fsh_exec fsh_exec_monitor fsh_exec_monitor_inst (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
  .I_CMD(I_CMD), .I_CMD_VALID(I_CMD_VALID), .O_CMD_READY(O_CMD_READY), .O_DMEM_WE(O_DMEM_WE),
  .O_DMEM_RE(O_DMEM_RE), .O_DMEM_ADDR(O_DMEM_ADDR), .O_PMEM_RE(O_PMEM_RE), .O_IO_WE(O_IO_WE),
  .O_IO_WDATA(O_IO_WDATA), .I_IO_RDATA(I_IO_RDATA), .I_REG_WE(I_REG_WE), .O_FLAGS(O_FLAGS));

// ==== verification/fsh_mem_model.sv ====
`timescale 1ns/100ps
module fsh_mem_model
(
  // Clock
  input  wire logic        i_clk,
  // Data memory
  input  wire logic [15:0] i_dmem_addr,
  input  wire logic [7:0]  i_dmem_wdata,
  input  wire logic        i_dmem_we,
  input  wire logic        i_dmem_re,
  output logic      [7:0]  o_dmem_rdata,
  // Program memory
  input  wire logic [15:0] i_pmem_addr,
  input  wire logic        i_pmem_re,
  output logic      [7:0]  o_pmem_rdata,
  // I/O space
  input  wire logic [5:0]  i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  input  wire logic        i_io_we,
  input  wire logic        i_io_re,
  output logic      [7:0]  o_io_rdata
);
  logic [7:0] dmem [65536];
  logic [7:0] io_mem [64];
  initial
  begin
    o_dmem_rdata = 8'h00;
    o_pmem_rdata = 8'h00;
  end
  // Data and program read data valid one cycle after the strobe only, toggling otherwise; I/O read data combinational, inverted without the strobe
  always @(posedge i_clk)
  begin
    if (i_dmem_we)
      dmem[i_dmem_addr] <= i_dmem_wdata;
    if (i_io_we)
      io_mem[i_io_addr] <= i_io_wdata;
    o_dmem_rdata <= i_dmem_re ? dmem[i_dmem_addr] : ~o_dmem_rdata;
    o_pmem_rdata <= i_pmem_re ? (i_pmem_addr[7:0] ^ 8'hA5) : ~o_pmem_rdata;
  end
  assign o_io_rdata = i_io_re ? io_mem[i_io_addr] : ~io_mem[i_io_addr];
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import fsh_pkg::*;
  logic clk, rstn, valid, rwe, rre, ready, dwe, dre, pre, iowe, iore;
  logic [1:0] raddr;
  logic [7:0] rwd, rrd_q, flags, dwd, drd, prd, iowd, iord, rd;
  logic [15:0] daddr, paddr;
  logic [5:0] ioaddr;
  fsh_cmd_t cmd;
  int fails, n_compared, busy, cyc;
  fsh_exec fsh_exec_inst (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_CMD(cmd), .I_CMD_VALID(valid),
    .O_CMD_READY(ready), .O_DMEM_ADDR(daddr), .O_DMEM_WDATA(dwd), .O_DMEM_WE(dwe), .O_DMEM_RE(dre),
    .I_DMEM_RDATA(drd), .O_PMEM_ADDR(paddr), .O_PMEM_RE(pre), .I_PMEM_RDATA(prd),
    .O_IO_ADDR(ioaddr), .O_IO_WDATA(iowd), .O_IO_WE(iowe), .O_IO_RE(iore), .I_IO_RDATA(iord),
    .I_REG_ADDR(raddr), .I_REG_WDATA(rwd), .I_REG_WE(rwe), .I_REG_RE(rre), .O_REG_RDATA(rrd_q),
    .O_FLAGS(flags));
  fsh_mem_model fsh_mem_model_inst (.i_clk(clk), .i_dmem_addr(daddr), .i_dmem_wdata(dwd),
    .i_dmem_we(dwe), .i_dmem_re(dre), .o_dmem_rdata(drd), .i_pmem_addr(paddr), .i_pmem_re(pre),
    .o_pmem_rdata(prd), .i_io_addr(ioaddr), .i_io_wdata(iowd), .i_io_we(iowe), .i_io_re(iore),
    .o_io_rdata(iord));
  always #20 clk = ~clk;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [7:0] dm(input logic [15:0] a);
    return fsh_mem_model_inst.dmem[a];
  endfunction
  task automatic run(input fsh_op_t op, input logic [4:0] d, input logic [4:0] s,
                     input fsh_ptr_t p, input logic [2:0] b, input logic [15:0] imm);
    @(posedge clk);
    cmd <= '{op, d, s, p, b, imm};
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    busy = 0;
    @(negedge clk);
    while (!ready && busy < 8)
    begin
      busy++;
      @(negedge clk);
    end
  endtask
  task automatic ld(input logic [4:0] r, input logic [7:0] v);
    fsh_mem_model_inst.io_mem[63] = v;
    run(OP_IN, r, 5'h00, PTR_X, 3'h0, 16'h003F);
  endtask
  task automatic getr(input logic [4:0] r, output logic [7:0] v);
    run(OP_OUT, 5'h00, r, PTR_X, 3'h0, 16'h003E);
    v = fsh_mem_model_inst.io_mem[62];
  endtask
  task automatic rwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    raddr <= a;
    rwd <= d;
    rwe <= 1'b1;
    @(posedge clk);
    rwe <= 1'b0;
  endtask
  task automatic rrd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    raddr <= a;
    rre <= 1'b1;
    @(posedge clk);
    rre <= 1'b0;
    @(negedge clk);
    d = rrd_q;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_store;
    ld(5, 8'hA7);
    getr(5, rd);
    chk("port", 16'h00A7, {8'h00, rd});
    chk("port busy", 16'h0000, 16'(busy));
    ld(26, 8'h10);
    ld(27, 8'h01);
    ld(3, 8'h5C);
    run(OP_PW_POSTINC, 5'h00, 5'h03, PTR_X, 3'h0, 16'h0000);
    chk("store busy", 16'h0001, 16'(busy));
    chk("store inc", 16'h005C, {8'h00, dm(16'h0110)});
    ld(3, 8'h3D);
    run(OP_PW_PREDEC, 5'h00, 5'h03, PTR_X, 3'h0, 16'h0000);
    chk("store dec", 16'h003D, {8'h00, dm(16'h0110)});
    ld(28, 8'h00);
    ld(29, 8'h02);
    run(OP_PW_DISP, 5'h00, 5'h03, PTR_Y, 3'h0, 16'h0005);
    chk("store disp", 16'h003D, {8'h00, dm(16'h0205)});
    getr(28, rd);
    chk("y kept", 16'h0000, {8'h00, rd});
    run(OP_DSTORE, 5'h00, 5'h05, PTR_X, 3'h0, 16'h1234);
    chk("store direct", 16'h00A7, {8'h00, dm(16'h1234)});
    chk("flags", 16'h0000, {8'h00, flags});
  endtask
  task automatic t_stack;
    rwr(REG_SPL, 8'h80);
    rwr(REG_SPH, 8'h10);
    run(OP_PUSH, 5'h00, 5'h05, PTR_X, 3'h0, 16'h0000);
    chk("push", 16'h00A7, {8'h00, dm(16'h1080)});
    rrd(REG_SPL, rd);
    chk("sp push", 16'h007F, {8'h00, rd});
    fsh_mem_model_inst.dmem[16'h1080] = 8'hC6;
    run(OP_POP, 5'h09, 5'h00, PTR_X, 3'h0, 16'h0000);
    chk("pop busy", 16'h0001, 16'(busy));
    getr(9, rd);
    chk("pop", 16'h00C6, {8'h00, rd});
    rwr(REG_STATUS, 8'hFF);
    rrd(REG_STATUS, rd);
    chk("status", 16'h0000, {8'h00, rd});
  endtask
  task automatic t_code;
    ld(30, 8'h40);
    ld(31, 8'h00);
    run(OP_CRD_R0, 5'h00, 5'h00, PTR_Z, 3'h0, 16'h0000);
    chk("code busy", 16'h0002, 16'(busy));
    getr(0, rd);
    chk("code r0", 16'h00E5, {8'h00, rd});
    run(OP_CRD_INC, 5'h07, 5'h00, PTR_Z, 3'h0, 16'h0000);
    getr(7, rd);
    chk("code rd", 16'h00E5, {8'h00, rd});
    getr(30, rd);
    chk("z inc", 16'h0041, {8'h00, rd});
  endtask
  task automatic t_bits;
    fsh_mem_model_inst.io_mem[5] = 8'hA0;
    run(OP_IOSET, 5'h00, 5'h00, PTR_X, 3'h2, 16'h0005);
    chk("io set", 16'h00A4, {8'h00, fsh_mem_model_inst.io_mem[5]});
    chk("set busy", 16'h0001, 16'(busy));
    run(OP_IOCLR, 5'h00, 5'h00, PTR_X, 3'h7, 16'h0005);
    chk("io clr", 16'h0024, {8'h00, fsh_mem_model_inst.io_mem[5]});
  endtask
  task automatic t_shift;
    fsh_op_t ops [5] = '{OP_SHL, OP_SHR, OP_RLC, OP_RRC, OP_SAR};
    logic [7:0] res [5] = '{8'h00, 8'h40, 8'h01, 8'hC0, 8'hC0};
    logic [4:0] cy = 5'h05;
    for (int i = 0; i < 5; i++)
    begin
      ld(12, 8'h80);
      rwr(REG_FLAG, 8'h01);
      run(ops[i], 5'h0C, 5'h0C, PTR_X, 3'h0, 16'h0000);
      chk("shift flags", {8'h00, 4'h0, res[i][7] ^ cy[i], res[i][7], res[i] == 8'h00, cy[i]},
          {8'h00, flags});
      getr(12, rd);
      chk("shift res", {8'h00, res[i]}, {8'h00, rd});
    end
  endtask
  task automatic t_flags;
    fsh_op_t ops [4] = '{OP_SSET, OP_VSET, OP_SCLR, OP_VCLR};
    logic [7:0] fx [4] = '{8'h50, 8'h58, 8'h48, 8'h40};
    rwr(REG_FLAG, 8'h00);
    run(OP_B2T, 5'h00, 5'h05, PTR_X, 3'h2, 16'h0000);
    chk("bit to t", 16'h0040, {8'h00, flags});
    ld(9, 8'h00);
    run(OP_T2B, 5'h09, 5'h00, PTR_X, 3'h3, 16'h0000);
    getr(9, rd);
    chk("t to bit", 16'h0008, {8'h00, rd});
    for (int i = 0; i < 4; i++)
    begin
      run(ops[i], 5'h00, 5'h00, PTR_X, 3'h0, 16'h0000);
      chk("flag op", {8'h00, fx[i]}, {8'h00, flags});
    end
  endtask
  task automatic finish_test;
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    valid = 1'b0;
    rwe = 1'b0;
    rre = 1'b0;
    raddr = 2'h0;
    rwd = 8'h00;
    cmd = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_store();
    t_stack();
    t_code();
    t_bits();
    t_shift();
    t_flags();
    finish_test();
  end
endmodule
